// file: rtl/acc_coef_bank.sv
// calibration coefficient register bank with apb slave
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// - primary gain holds 16-bit scaling coefficient
// - auxiliary gain holds 16-bit scaling coefficient
// - auxiliary offset holds 16-bit coefficient
// - primary gain bits 15:0 readable writable
// - power-on loads factory default coefficients
// - primary gain calibration overwrites primary gain
// - auxiliary gain calibration overwrites auxiliary gain
// - coefficient writes accepted only while idle
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_coef_bank
  import acc_pkg::*;
#(
  parameter logic [15:0] PRI_GAIN_DEF = `ACC_PRI_GAIN_DEF,
  parameter logic [15:0] AUX_GAIN_DEF = `ACC_AUX_GAIN_DEF,
  parameter logic [15:0] AUX_OFFS_DEF = `ACC_AUX_OFFS_DEF,
  parameter int IDLE_CYC = `ACC_IDLE_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pri_cal_done,
  input wire logic [15:0] pri_cal_gain,
  input wire logic aux_cal_done,
  input wire logic [15:0] aux_cal_gain,
  output logic [15:0] pri_gain_coef,
  output logic [15:0] aux_gain_coef,
  output logic [15:0] aux_offs_coef,
  output logic conv_enable,
  output logic [2:0] conv_mode
);

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  acc_state_type s_r;
  acc_state_type s_nxt;

  logic access;
  logic wr;
  logic rd;
  logic hit_pg;
  logic hit_ag;
  logic hit_ao;
  logic hit_ct;
  logic hit_st;
  logic hit_any;
  logic coef_wr;
  logic idle_now;
  logic gain_cal_mode;
  logic pri_cal_load;
  logic aux_cal_load;
  logic [15:0] coef_wdata;

  //------------------------------------------------------------
  // apb decode
  //------------------------------------------------------------
  assign access = psel && penable;
  assign wr = access && pwrite;
  // reads are captured in the setup cycle, so the data already stands
  // in the access phase and the slave needs no wait state
  assign rd = psel && !penable && !pwrite;
  assign hit_pg = (paddr == `ACC_PRI_GAIN_OFS);
  assign hit_ag = (paddr == `ACC_AUX_GAIN_OFS);
  assign hit_ao = (paddr == `ACC_AUX_OFFS_OFS);
  assign hit_ct = (paddr == `ACC_CTRL_OFS);
  assign hit_st = (paddr == `ACC_STAT_OFS);
  assign hit_any = hit_pg || hit_ag || hit_ao || hit_ct || hit_st;
  assign coef_wr = wr && (hit_pg || hit_ag || hit_ao);
  // converter must be enabled and idle; the 23 us wait is software's duty
  assign idle_now = s_r.enable && (s_r.mode == ACC_MODE_IDLE);
  assign coef_wdata = pwdata[`ACC_COEF_MSB:0];

  //------------------------------------------------------------
  // calibration loads
  //------------------------------------------------------------
  // results are taken only while a gain calibration is running; a stray
  // done pulse in any other mode leaves the coefficients alone
  assign gain_cal_mode = s_r.enable
    && (s_r.mode == ACC_MODE_SELF_GAIN || s_r.mode == ACC_MODE_SYS_GAIN);
  assign pri_cal_load = pri_cal_done && gain_cal_mode;
  assign aux_cal_load = aux_cal_done && gain_cal_mode;

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    // idle time is tracked only for status; the wait is not enforced
    if (!idle_now)
    begin
      s_nxt.idle_cnt = '0;
      s_nxt.idle_ready = 1'b0;
    end
    else if (s_r.idle_cnt >= 15'(IDLE_CYC - 1))
    begin
      // the count stops at the limit, so a long idle spell never wraps
      s_nxt.idle_ready = 1'b1;
    end
    else
    begin
      s_nxt.idle_cnt = s_r.idle_cnt + 15'h0001;
    end
    // leaving idle mode clears the idle timer on the following cycle
    if (wr && hit_ct)
    begin
      s_nxt.enable = pwdata[`ACC_CTRL_EN_BIT];
      s_nxt.mode = acc_mode_type'(pwdata[`ACC_CTRL_MODE_MSB:`ACC_CTRL_MODE_LSB]);
    end
    if (coef_wr && idle_now)
    begin
      if (hit_pg)
      begin
        s_nxt.pri_gain = coef_wdata;
      end
      if (hit_ag)
      begin
        s_nxt.aux_gain = coef_wdata;
      end
      if (hit_ao)
      begin
        s_nxt.aux_offs = coef_wdata;
      end
    end
    // a non-idle coefficient write is dropped and flagged
    if (coef_wr && !idle_now)
    begin
      s_nxt.drop = 1'b1;
    end
    else if (wr && hit_st)
    begin
      s_nxt.drop = 1'b0;
    end
    // calibration result wins over a same-cycle software write
    if (pri_cal_load)
    begin
      s_nxt.pri_gain = pri_cal_gain;
    end
    if (aux_cal_load)
    begin
      s_nxt.aux_gain = aux_cal_gain;
    end
    if (rd)
    begin
      // upper bits of every coefficient read back as zero
      s_nxt.prdata = '0;
      case (1'b1)
        hit_pg: s_nxt.prdata[`ACC_COEF_MSB:0] = s_r.pri_gain;
        hit_ag: s_nxt.prdata[`ACC_COEF_MSB:0] = s_r.aux_gain;
        hit_ao: s_nxt.prdata[`ACC_COEF_MSB:0] = s_r.aux_offs;
        hit_ct:
        begin
          s_nxt.prdata[`ACC_CTRL_EN_BIT] = s_r.enable;
          s_nxt.prdata[`ACC_CTRL_MODE_MSB:`ACC_CTRL_MODE_LSB] = s_r.mode;
        end
        hit_st:
        begin
          s_nxt.prdata[`ACC_STAT_IDLE_BIT] = idle_now;
          s_nxt.prdata[`ACC_STAT_READY_BIT] = s_r.idle_ready;
          s_nxt.prdata[`ACC_STAT_DROP_BIT] = s_r.drop;
          s_nxt.prdata[`ACC_STAT_MODE_MSB:`ACC_STAT_MODE_LSB] = s_r.mode;
        end
        default: s_nxt.prdata = '0;
      endcase
    end
  end

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  // factory values come in as parameters, standing in for trimmed fuses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r.pri_gain <= PRI_GAIN_DEF;
      s_r.aux_gain <= AUX_GAIN_DEF;
      s_r.aux_offs <= AUX_OFFS_DEF;
      s_r.enable <= 1'b0;
      s_r.mode <= ACC_MODE_OFF;
      s_r.idle_cnt <= '0;
      s_r.idle_ready <= 1'b0;
      s_r.drop <= 1'b0;
      s_r.prdata <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // zero wait states: read data was registered at the setup edge; a calibration
  // landing in the access phase shows only on the next read
  assign pready = access;
  assign pslverr = access && !hit_any;
  assign prdata = s_r.prdata;
  assign pri_gain_coef = s_r.pri_gain;
  assign aux_gain_coef = s_r.aux_gain;
  assign aux_offs_coef = s_r.aux_offs;
  assign conv_enable = s_r.enable;
  assign conv_mode = s_r.mode;

endmodule

// file: rtl/acc_defines.svh
// register offsets, field positions and timing counts for the calibration coefficient bank
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

`define ACC_PRI_GAIN_OFS 32'hFFFF052C
`define ACC_AUX_GAIN_OFS 32'hFFFF0530
`define ACC_AUX_OFFS_OFS 32'hFFFF0528
`define ACC_CTRL_OFS 32'hFFFF0540
`define ACC_STAT_OFS 32'hFFFF0544
`define ACC_ADDR_LSB 2
`define ACC_ADDR_MSB 11
`define ACC_COEF_MSB 15
`define ACC_COEF_W 16
`define ACC_CTRL_EN_BIT 0
`define ACC_CTRL_MODE_LSB 1
`define ACC_CTRL_MODE_MSB 3
`define ACC_CTRL_MODE_W 3
`define ACC_STAT_IDLE_BIT 0
`define ACC_STAT_READY_BIT 1
`define ACC_STAT_DROP_BIT 2
`define ACC_STAT_MODE_LSB 4
`define ACC_STAT_MODE_MSB 6
`define ACC_IDLE_NS 23000
`define ACC_CLK_NS 10
`define ACC_IDLE_CYC ((`ACC_IDLE_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`define ACC_PRI_GAIN_DEF 16'h5555
`define ACC_AUX_GAIN_DEF 16'h5555
`define ACC_AUX_OFFS_DEF 16'h8000

`endif

// file: rtl/acc_pkg.sv
// types for the calibration coefficient bank
package acc_pkg;

  typedef enum logic [2:0]
  {
    ACC_MODE_OFF = 3'b000,
    ACC_MODE_IDLE = 3'b001,
    ACC_MODE_CONT = 3'b010,
    ACC_MODE_SINGLE = 3'b011,
    ACC_MODE_SYS_OFS = 3'b100,
    ACC_MODE_SYS_GAIN = 3'b101,
    ACC_MODE_SELF_OFS = 3'b110,
    ACC_MODE_SELF_GAIN = 3'b111
  } acc_mode_type;

  typedef struct packed
  {
    logic [15:0] pri_gain;
    logic [15:0] aux_gain;
    logic [15:0] aux_offs;
    logic enable;
    acc_mode_type mode;
    logic [14:0] idle_cnt;
    logic idle_ready;
    logic drop;
    logic [31:0] prdata;
  } acc_state_type;

endpackage

// file: tb/acc_coef_bank_assertions.sv
// assertions on the calibration coefficient bank ports
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_coef_bank_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pri_cal_done,
  input wire logic [15:0] pri_cal_gain,
  input wire logic aux_cal_done,
  input wire logic [15:0] aux_cal_gain,
  input wire logic [15:0] pri_gain_coef,
  input wire logic [15:0] aux_gain_coef,
  input wire logic [15:0] aux_offs_coef,
  input wire logic conv_enable,
  input wire logic [2:0] conv_mode
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic wr = psel && penable && pwrite;
  wire logic idle = conv_enable && conv_mode == 3'h1;
  wire logic gcal = conv_enable && conv_mode[2] && conv_mode[0];
  AST_WR_PRI: assert property (wr && idle && !pri_cal_done && paddr == `ACC_PRI_GAIN_OFS
    |=> pri_gain_coef == $past(pwdata[15:0])) else $error("pri gain write lost");
  AST_WR_AUX: assert property (wr && idle && !aux_cal_done && paddr == `ACC_AUX_GAIN_OFS
    |=> aux_gain_coef == $past(pwdata[15:0])) else $error("aux gain write lost");
  AST_WR_OFS: assert property (wr && idle && paddr == `ACC_AUX_OFFS_OFS
    |=> aux_offs_coef == $past(pwdata[15:0])) else $error("aux offset write lost");
  AST_DROP: assert property (wr && !idle && !aux_cal_done && paddr == `ACC_AUX_GAIN_OFS
    |=> $stable(aux_gain_coef)) else $error("busy write not dropped");
  AST_BUSY: assert property (wr && !idle && !pri_cal_done && paddr == `ACC_PRI_GAIN_OFS
    |=> $stable(pri_gain_coef)) else $error("write taken while busy");
  AST_CAL_PRI: assert property (pri_cal_done && gcal
    |=> pri_gain_coef == $past(pri_cal_gain)) else $error("pri cal not loaded");
  AST_CAL_AUX: assert property (aux_cal_done && gcal
    |=> aux_gain_coef == $past(aux_cal_gain)) else $error("aux cal not loaded");
  AST_HOLD: assert property (!wr && !pri_cal_done |=> $stable(pri_gain_coef))
    else $error("pri gain changed alone");
  AST_RD: assert property (psel && !penable && !pwrite && paddr == `ACC_PRI_GAIN_OFS
    |=> prdata == {16'h0000, $past(pri_gain_coef)}) else $error("pri gain read wrong");
endmodule

bind acc_coef_bank acc_coef_bank_chk chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pri_cal_done(pri_cal_done), .pri_cal_gain(pri_cal_gain), .aux_cal_done(aux_cal_done),
  .aux_cal_gain(aux_cal_gain), .pri_gain_coef(pri_gain_coef), .aux_gain_coef(aux_gain_coef),
  .aux_offs_coef(aux_offs_coef), .conv_enable(conv_enable), .conv_mode(conv_mode));

// file: tb/test_acc_coef_bank.sv
// self-checking bench for the calibration coefficient bank
`timescale 1ns/1ps
`include "acc_defines.svh"
module test_acc_coef_bank;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
  logic pri_cal_done = 1'b0, aux_cal_done = 1'b0, pready, pslverr, conv_enable, err_seen;
  logic [15:0] pri_cal_gain = 16'h0, aux_cal_gain = 16'h0;
  logic [15:0] pri_gain_coef, aux_gain_coef, aux_offs_coef;
  logic [2:0] conv_mode;
  logic [31:0] rdv;
  int errors = 0;
  int samples_checked = 0;
  acc_coef_bank #(.IDLE_CYC(`ACC_IDLE_CYC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pri_cal_done(pri_cal_done),
    .pri_cal_gain(pri_cal_gain), .aux_cal_done(aux_cal_done), .aux_cal_gain(aux_cal_gain),
    .pri_gain_coef(pri_gain_coef), .aux_gain_coef(aux_gain_coef),
    .aux_offs_coef(aux_offs_coef), .conv_enable(conv_enable), .conv_mode(conv_mode));
  always #5 pclk = ~pclk;
  // the answer, read data included, is taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    err_seen = pslverr;
    rdv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, nm);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ACC_PRI_GAIN_OFS, {16'h0000, `ACC_PRI_GAIN_DEF}, "pri default");
    rd(`ACC_AUX_GAIN_OFS, {16'h0000, `ACC_AUX_GAIN_DEF}, "aux default");
    rd(`ACC_AUX_OFFS_OFS, {16'h0000, `ACC_AUX_OFFS_DEF}, "ofs default");
    apb(1'b1, `ACC_PRI_GAIN_OFS, 32'h00001111);
    rd(`ACC_PRI_GAIN_OFS, {16'h0000, `ACC_PRI_GAIN_DEF}, "pri while off");
    rd(`ACC_STAT_OFS, 32'h00000004, "drop while off");
    $display("test reset done");
    apb(1'b1, `ACC_CTRL_OFS, 32'h00000003);
    repeat (`ACC_IDLE_CYC) @(posedge pclk);
    rd(`ACC_STAT_OFS, 32'h00000017, "idle status");
    apb(1'b1, `ACC_STAT_OFS, 32'h00000000);
    rd(`ACC_CTRL_OFS, 32'h00000003, "ctrl readback");
    apb(1'b1, `ACC_PRI_GAIN_OFS, 32'hFFFFA5C3);
    apb(1'b1, `ACC_AUX_GAIN_OFS, 32'h00001234);
    apb(1'b1, `ACC_AUX_OFFS_OFS, 32'h0000FEDC);
    rd(`ACC_PRI_GAIN_OFS, 32'h0000A5C3, "pri gain");
    rd(`ACC_AUX_GAIN_OFS, 32'h00001234, "aux gain");
    rd(`ACC_AUX_OFFS_OFS, 32'h0000FEDC, "aux offset");
    chk({16'h0000, pri_gain_coef}, 32'h0000A5C3, "pri coef port");
    chk({16'h0000, aux_gain_coef}, 32'h00001234, "aux coef port");
    chk({16'h0000, aux_offs_coef}, 32'h0000FEDC, "ofs coef port");
    chk({28'h0, conv_mode, conv_enable}, 32'h00000003, "ctrl ports");
    rd(`ACC_STAT_OFS, 32'h00000013, "drop cleared");
    apb(1'b1, 32'hFFFF0600, 32'h0);
    chk({31'h0, err_seen}, 32'h1, "unmapped error");
    $display("test idle writes done");
    apb(1'b1, `ACC_CTRL_OFS, 32'h0000000F);
    pri_cal_done <= 1'b1;
    aux_cal_done <= 1'b1;
    pri_cal_gain <= 16'h2468;
    aux_cal_gain <= 16'h1357;
    @(posedge pclk);
    pri_cal_done <= 1'b0;
    aux_cal_done <= 1'b0;
    @(posedge pclk);
    rd(`ACC_PRI_GAIN_OFS, 32'h00002468, "pri cal");
    rd(`ACC_AUX_GAIN_OFS, 32'h00001357, "aux cal");
    apb(1'b1, `ACC_AUX_GAIN_OFS, 32'h00007777);
    rd(`ACC_AUX_GAIN_OFS, 32'h00001357, "aux while cal");
    $display("test calibration done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`ACC_PRI_GAIN_OFS, {16'h0000, `ACC_PRI_GAIN_DEF}, "pri after reset");
    rd(`ACC_AUX_GAIN_OFS, {16'h0000, `ACC_AUX_GAIN_DEF}, "aux after reset");
    chk({28'h0, conv_mode, conv_enable}, 32'h00000000, "ctrl after reset");
    $display("test second reset done");
    report_and_stop();
  end
endmodule
